// *** logic/zone_fuse_access_control.sv ***
// Functional notes
// - erase counting for zone two only in mode 2 with enable fuse at 1
// - with counting active, at most 128 zone two erases between resets
// - all 128 counter bits at 0 and the last bit's erase spent blocks any further zone two erase
// - counter bits can only be written, never erased back to 1
// - enable fuse blown: unlimited zone two erases, counter ignored
// - test zone read, write, erase always allowed, no code needed
// - maker zone always readable
// - maker zone write or erase needs the validated flag
// - maker lock fuse blown makes maker zone read-only
// - issuer fuse blown also makes maker zone read-only
// - issuer fuse blown freezes the counter enable fuse
// - issuer fuse reading 1 means mode 1, reading 0 means mode 2
// - unblown fuse bit is 1, blown fuse bit is 0
// - validated flag set on correct code check, gates write and erase
// - in mode 2 zone two erases only as a whole block
// - mode 2 zone two erase needs code and erase key validated
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module zone_fuse_access_control
    import access_ctl_pkg::*;
#(
    parameter int PROG_LEN = PROG_CYCLES
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        code_match_ok,
    input  wire logic        erase_key_ok,
    output logic             az2_erase_pulse,
    output logic             az2_erase_block,
    output logic      [4:0]  az2_erase_word,
    output logic             prog_busy
);
    // stored cells and fuses
    logic [15:0]  test_zone_r;
    logic [15:0]  test_zone_nxt;
    logic [15:0]  maker_zone_r;
    logic [15:0]  maker_zone_nxt;
    logic [127:0] ec_r;
    logic [127:0] ec_nxt;
    logic [15:0]  issuer_r;
    logic [15:0]  issuer_nxt;
    logic         ecen_r;
    logic         ecen_nxt;
    logic         mlock_r;
    logic         mlock_nxt;
    // session flags; code_ok_r and key_r cleared only by reset
    logic         code_ok_r;
    logic         code_ok_nxt;
    logic         key_r;
    logic         key_nxt;
    logic         armed_r;
    logic         armed_nxt;
    logic         refused_r;
    logic         refused_nxt;
    // bus and outputs
    logic         ack_r;
    logic         ack_nxt;
    logic [31:0]  dat_r;
    logic [31:0]  dat_nxt;
    logic         pulse_r;
    logic         pulse_nxt;
    logic         block_r;
    logic         block_nxt;
    logic [4:0]   word_r;
    logic [4:0]   word_nxt;

    logic         wb_req;
    logic         cmd_go;
    logic         go_ok;
    logic         allow;
    logic [1:0]   op;
    logic [2:0]   tgt;
    logic [6:0]   idx;
    logic         mode2;
    logic         count_act;
    logic         ec_empty;
    logic         busy;
    logic [31:0]  status;

    // one request per cycle; ack_r blocks a second take of the same one
    assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
    assign cmd_go = wb_req & wb_we_i & (wb_adr_i == ADDR_CMD)
                  & wb_sel_i[0] & wb_sel_i[1];
    assign op     = wb_dat_i[CMD_OP_LSB +: 2];
    assign tgt    = wb_dat_i[CMD_TGT_LSB +: 3];
    assign idx    = wb_dat_i[CMD_IDX_LSB +: 7];

    // fuse reading 1 is unblown; issuer word at 0 means mode 2
    assign mode2     = ~|issuer_r;
    assign count_act = mode2 & ecen_r;
    assign ec_empty  = ~|ec_r;

    // access decision for the command on the bus
    always_comb begin
        allow = 1'b0;
        unique case (tgt)
            TGT_TEST: begin
                allow = (op == OP_WRITE) | (op == OP_ERASE);
            end
            TGT_MAKER: begin
                allow = ((op == OP_WRITE) | (op == OP_ERASE))
                      & code_ok_r & mlock_r & ~mode2;
            end
            TGT_EC: begin
                // erase never allowed; write only of a still-set bit
                allow = (op == OP_WRITE) & code_ok_r & ec_r[idx];
            end
            TGT_AZ2: begin
                if (mode2) begin
                    // one written bit buys one erase, the last one too
                    allow = (op == OP_ERASE) & code_ok_r & key_r
                          & (~count_act | armed_r);
                end else begin
                    allow = (op == OP_ERASE) & code_ok_r;
                end
            end
            TGT_ECEN: begin
                allow = ((op == OP_WRITE) | (op == OP_ERASE))
                      & code_ok_r & ~mode2;
            end
            TGT_MLOCK, TGT_ISSUER: begin
                allow = (op == OP_WRITE) & code_ok_r;
            end
            default: begin
                allow = 1'b0;
            end
        endcase
    end

    // a busy programming cycle refuses any new command
    assign go_ok = cmd_go & allow & ~busy;

    // next state of cells, fuses and flags
    always_comb begin
        test_zone_nxt  = test_zone_r;
        maker_zone_nxt = maker_zone_r;
        ec_nxt         = ec_r;
        issuer_nxt     = issuer_r;
        ecen_nxt       = ecen_r;
        mlock_nxt      = mlock_r;
        armed_nxt      = armed_r;
        pulse_nxt      = 1'b0;
        block_nxt      = block_r;
        word_nxt       = word_r;
        code_ok_nxt    = code_ok_r | code_match_ok;
        key_nxt        = key_r | erase_key_ok;
        refused_nxt    = cmd_go ? ~(allow & ~busy) : refused_r;
        if (go_ok) begin
            unique case (tgt)
                TGT_TEST: begin
                    if (op == OP_WRITE) begin
                        test_zone_nxt[idx[3:0]] = 1'b0;
                    end else begin
                        test_zone_nxt = TEST_RST;
                    end
                end
                TGT_MAKER: begin
                    if (op == OP_WRITE) begin
                        maker_zone_nxt[idx[3:0]] = 1'b0;
                    end else begin
                        maker_zone_nxt = MAKER_RST;
                    end
                end
                TGT_EC: begin
                    ec_nxt[idx] = 1'b0;
                    armed_nxt   = 1'b1;
                end
                TGT_AZ2: begin
                    pulse_nxt = 1'b1;
                    block_nxt = mode2;
                    word_nxt  = idx[4:0];
                    armed_nxt = 1'b0;
                end
                TGT_ECEN: begin
                    ecen_nxt = (op == OP_ERASE);
                end
                TGT_MLOCK: begin
                    mlock_nxt = 1'b0;
                end
                TGT_ISSUER: begin
                    // blown as one word so the mode flips cleanly
                    issuer_nxt = '0;
                    armed_nxt  = 1'b0;  // mode 1 writes buy no erase
                end
                default: begin
                    armed_nxt = armed_r;
                end
            endcase
        end
    end

    // status word shows the block's own state
    always_comb begin
        status              = '0;
        status[ST_MODE2]    = mode2;
        status[ST_CODE_OK]  = code_ok_r;
        status[ST_KEY]      = key_r;
        status[ST_BUSY]     = busy;
        status[ST_REFUSED]  = refused_r;
        status[ST_COUNT]    = count_act;
        status[ST_EMPTY]    = ec_empty;
        status[ST_ARMED]    = armed_r;
    end

    // bus answer: ack one cycle after the request, read data with it
    always_comb begin
        ack_nxt = wb_req;
        dat_nxt = dat_r;
        if (wb_req & ~wb_we_i) begin
            unique case (wb_adr_i)
                ADDR_STATUS: dat_nxt = status;
                ADDR_TEST:   dat_nxt = {16'h0000, test_zone_r};
                ADDR_MAKER:  dat_nxt = {16'h0000, maker_zone_r};
                ADDR_FUSE: begin
                    dat_nxt = {14'h0000, mlock_r, ecen_r, issuer_r};
                end
                ADDR_CNT0:   dat_nxt = ec_r[31:0];
                ADDR_CNT1:   dat_nxt = ec_r[63:32];
                ADDR_CNT2:   dat_nxt = ec_r[95:64];
                ADDR_CNT3:   dat_nxt = ec_r[127:96];
                default:     dat_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            test_zone_r  <= TEST_RST;
            maker_zone_r <= MAKER_RST;
            ec_r         <= EC_RST;
            issuer_r     <= ISSUER_RST;
            ecen_r       <= ECEN_RST;
            mlock_r      <= MLOCK_RST;
            code_ok_r    <= 1'b0;
            key_r        <= 1'b0;
            armed_r      <= 1'b0;
            refused_r    <= 1'b0;
            ack_r        <= 1'b0;
            dat_r        <= 32'h0000_0000;
            pulse_r      <= 1'b0;
            block_r      <= 1'b0;
            word_r       <= 5'h00;
        end else begin
            test_zone_r  <= test_zone_nxt;
            maker_zone_r <= maker_zone_nxt;
            ec_r         <= ec_nxt;
            issuer_r     <= issuer_nxt;
            ecen_r       <= ecen_nxt;
            mlock_r      <= mlock_nxt;
            code_ok_r    <= code_ok_nxt;
            key_r        <= key_nxt;
            armed_r      <= armed_nxt;
            refused_r    <= refused_nxt;
            ack_r        <= ack_nxt;
            dat_r        <= dat_nxt;
            pulse_r      <= pulse_nxt;
            block_r      <= block_nxt;
            word_r       <= word_nxt;
        end
    end

    // accepted operations hold off further commands while programming
    prog_timer #(
        .CYCLES (PROG_LEN)
    ) u_timer (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .start    (go_ok),
        .busy     (busy)
    );

    assign wb_ack_o        = ack_r;
    assign wb_dat_o        = dat_r;
    assign az2_erase_pulse = pulse_r;
    assign az2_erase_block = block_r;
    assign az2_erase_word  = word_r;
    assign prog_busy       = busy;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_ec_no_erase: assert property (
        ((~$past(ec_r)) & ec_r) == '0)
        else $error("erase counter bit returned to 1");

    chk_limit_block: assert property (
        pulse_r && $past(count_act) |-> $past(armed_r))
        else $error("counted zone two erase without a spent bit");

    chk_test_erase: assert property (
        go_ok && tgt == TGT_TEST && op == OP_ERASE
        |=> test_zone_r == TEST_RST)
        else $error("test zone erase did not take");

    chk_maker_locked: assert property (
        (!mlock_r || mode2) |=> $stable(maker_zone_r))
        else $error("locked maker zone changed");

    chk_maker_code: assert property (
        !code_ok_r |=> $stable(maker_zone_r))
        else $error("maker zone changed without validation");

    chk_ecen_frozen: assert property (
        mode2 |=> $stable(ecen_r))
        else $error("enable fuse changed in mode 2");

    chk_refuse_idle: assert property (
        cmd_go && !allow && !busy |=> !busy && !pulse_r)
        else $error("refused command started programming");

    chk_block_erase: assert property (
        pulse_r && $past(mode2) |-> block_r)
        else $error("word erase of zone two in mode 2");

    chk_az2_keys: assert property (
        pulse_r && $past(mode2) |-> $past(code_ok_r) && $past(key_r))
        else $error("zone two erase without code and key");

    chk_unlimited: assert property (
        cmd_go && tgt == TGT_AZ2 && op == OP_ERASE && mode2 && !ecen_r
        && code_ok_r && key_r && !busy |=> pulse_r)
        else $error("zone two erase refused with counting off");

    chk_bus_ack: assert property (
        wb_cyc_i && wb_stb_i && !ack_r |=> ack_r ##1 !ack_r)
        else $error("bus ack not a single cycle after request");
endmodule
`default_nettype wire

// *** logic/access_ctl_pkg.sv ***
`default_nettype none
package access_ctl_pkg;

    // register byte offsets on the bus
    localparam logic [7:0] ADDR_CMD    = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TEST   = 8'h08;
    localparam logic [7:0] ADDR_MAKER  = 8'h0c;
    localparam logic [7:0] ADDR_FUSE   = 8'h10;
    localparam logic [7:0] ADDR_CNT0   = 8'h14;
    localparam logic [7:0] ADDR_CNT1   = 8'h18;
    localparam logic [7:0] ADDR_CNT2   = 8'h1c;
    localparam logic [7:0] ADDR_CNT3   = 8'h20;

    // command word fields
    localparam int CMD_OP_LSB  = 0;
    localparam int CMD_TGT_LSB = 4;
    localparam int CMD_IDX_LSB = 8;

    // operation codes
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_ERASE = 2'h2;

    // operation targets
    localparam logic [2:0] TGT_TEST   = 3'h0;
    localparam logic [2:0] TGT_MAKER  = 3'h1;
    localparam logic [2:0] TGT_EC     = 3'h2;
    localparam logic [2:0] TGT_AZ2    = 3'h3;
    localparam logic [2:0] TGT_ECEN   = 3'h4;
    localparam logic [2:0] TGT_MLOCK  = 3'h5;
    localparam logic [2:0] TGT_ISSUER = 3'h6;

    // fuse word positions
    localparam int FUSE_ECEN_BIT  = 16;
    localparam int FUSE_MLOCK_BIT = 17;

    // status bit positions
    localparam int ST_MODE2   = 0;
    localparam int ST_CODE_OK = 1;
    localparam int ST_KEY     = 2;
    localparam int ST_BUSY    = 3;
    localparam int ST_REFUSED = 4;
    localparam int ST_COUNT   = 5;
    localparam int ST_EMPTY   = 6;
    localparam int ST_ARMED   = 7;

    // sizes
    localparam int EC_BITS   = 128;
    localparam int ZONE_BITS = 16;

    // values after reset: every fuse and cell unblown / erased
    localparam logic [15:0]  TEST_RST   = 16'hffff;
    localparam logic [15:0]  MAKER_RST  = 16'hffff;
    localparam logic [15:0]  ISSUER_RST = 16'hffff;
    localparam logic [127:0] EC_RST     = {128{1'b1}};
    localparam logic         ECEN_RST   = 1'b1;
    localparam logic         MLOCK_RST  = 1'b1;

    // programming cycle length in core clocks
    localparam int PROG_CYCLES = 8;

endpackage
`default_nettype wire

// *** logic/prog_timer.sv ***
`timescale 1ns/1ps
`default_nettype none
module prog_timer #(
    parameter int CYCLES = 8
) (
    input  wire logic core_clk,
    input  wire logic rst_n,
    input  wire logic start,
    output logic      busy
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(CYCLES);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // load on start, count down to idle
    always_comb begin
        cnt_nxt = cnt_r;
        if (start) begin
            cnt_nxt = CNT_LOAD;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign busy = (cnt_r != '0);
endmodule
`default_nettype wire

// *** testbench/card_reader.sv ***
`timescale 1ns/1ps
`default_nettype none
module card_reader (
    input  wire logic        core_clk,
    output var  logic        wb_cyc_i,
    output var  logic        wb_stb_i,
    output var  logic        wb_we_i,
    output var  logic [7:0]  wb_adr_i,
    output var  logic [3:0]  wb_sel_i,
    output var  logic [31:0] wb_dat_i,
    input  wire logic [31:0] wb_dat_o,
    input  wire logic        wb_ack_o,
    output var  logic        code_match_ok,
    output var  logic        erase_key_ok
);
    int idle_gap;

    // idle bus at time zero, no flag raised
    initial begin
        wb_cyc_i     = 1'b0;
        wb_stb_i     = 1'b0;
        wb_we_i      = 1'b0;
        wb_adr_i     = 8'h00;
        wb_sel_i     = 4'h0;
        wb_dat_i     = 32'h0;
        code_match_ok = 1'b0;
        erase_key_ok = 1'b0;
        idle_gap     = 0;
    end

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [31:0] dat, output logic [31:0] rd);
        repeat (idle_gap + 1) @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hf;
        wb_dat_i <= dat;
        @(posedge core_clk);
        // no limit here: only the bench watchdog ends a hung wait
        while (wb_ack_o !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = wb_dat_o;
        // released lines flip so stale values never look valid
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= ~we;
        wb_adr_i <= ~adr;
        wb_dat_i <= ~dat;
    endtask

    // one-cycle report from the code or key comparison
    task automatic present(input logic key);
        @(posedge core_clk);
        if (key) begin
            erase_key_ok <= 1'b1;
        end else begin
            code_match_ok <= 1'b1;
        end
        @(posedge core_clk);
        erase_key_ok  <= 1'b0;
        code_match_ok <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import access_ctl_pkg::*;
    localparam int PLEN = 2;
    typedef struct {
        logic [1:0]  kind;
        logic [7:0]  adr;
        logic [31:0] dat;
    } row_t;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b0;
    logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, prog_busy;
    logic        code_match_ok, erase_key_ok, st;
    logic        az2_erase_pulse, az2_erase_block;
    logic [4:0]  az2_erase_word;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd, pw;
    int          bad_count = 0;
    int          tests_run = 0;
    int          pulses    = 0;
    int          p0;
    row_t        rows[19];

    always #5 core_clk = ~core_clk;

    zone_fuse_access_control #(.PROG_LEN(PLEN)) u_zone_fuse_access_control (
        .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .code_match_ok(code_match_ok),
        .erase_key_ok(erase_key_ok), .az2_erase_pulse(az2_erase_pulse),
        .az2_erase_block(az2_erase_block), .az2_erase_word(az2_erase_word),
        .prog_busy(prog_busy));

    card_reader u_card_reader (
        .core_clk(core_clk), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .code_match_ok(code_match_ok), .erase_key_ok(erase_key_ok));

    // erase pulse monitor; block and word only count with the pulse
    always @(posedge core_clk) begin
        if (az2_erase_pulse === 1'b1) begin
            pulses <= pulses + 1;
            pw     <= {26'h0, az2_erase_block, az2_erase_word};
        end
    end

    function automatic logic [31:0] cw(logic [1:0] op, logic [2:0] tgt,
                                       logic [6:0] idx);
        return 32'(idx) << CMD_IDX_LSB | 32'(tgt) << CMD_TGT_LSB
             | 32'(op) << CMD_OP_LSB;
    endfunction

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [31:0] exp);
        u_card_reader.bus(1'b0, adr, 32'h0, rd);
        check($sformatf("reg %h", adr), exp, rd);
    endtask

    // busy must clear before the next command, else it is refused
    task automatic wait_idle;
        while (prog_busy !== 1'b0) begin
            @(posedge core_clk);
        end
    endtask

    task automatic cmd(input logic [1:0] op, input logic [2:0] tgt,
                       input logic [6:0] idx, output logic started);
        u_card_reader.bus(1'b1, ADDR_CMD, cw(op, tgt, idx), rd);
        started = prog_busy;
        wait_idle();
    endtask

    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
    endtask

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // about 1500 cycles expected; a hang is cut off well beyond that
    initial begin
        repeat (40000) @(posedge core_clk);
        bad_count++;
        end_of_test();
    end

    initial begin
        rows = '{
            '{0, ADDR_TEST,   32'h0000ffff},
            '{0, ADDR_FUSE,   32'h0003ffff},
            '{0, ADDR_STATUS, 32'h00000000},
            '{0, 8'hfc,       32'h00000000},
            '{1, 8'h00, cw(OP_WRITE, TGT_TEST, 7'd3)},
            '{0, ADDR_TEST,   32'h0000fff7},
            '{1, 8'h00, cw(OP_WRITE, TGT_MAKER, 7'd0)},
            '{0, ADDR_MAKER,  32'h0000ffff},
            '{2, ADDR_STATUS, 32'h00000012},
            '{1, 8'h00, cw(OP_WRITE, TGT_MAKER, 7'd0)},
            '{0, ADDR_MAKER,  32'h0000fffe},
            '{1, 8'h00, cw(OP_WRITE, TGT_MLOCK, 7'd0)},
            '{0, ADDR_FUSE,   32'h0001ffff},
            '{1, 8'h00, cw(OP_ERASE, TGT_MAKER, 7'd0)},
            '{0, ADDR_MAKER,  32'h0000fffe},
            '{0, ADDR_STATUS, 32'h00000012},
            '{1, 8'h00, cw(OP_ERASE, TGT_TEST, 7'd0)},
            '{0, ADDR_TEST,   32'h0000ffff},
            '{0, ADDR_MAKER,  32'h0000fffe}
        };
        do_reset();
        // table rows: 0 read and compare, 1 command, 2 code then status
        foreach (rows[i]) begin
            case (rows[i].kind)
                2'd0: rdchk(rows[i].adr, rows[i].dat);
                2'd1: begin
                    u_card_reader.bus(1'b1, ADDR_CMD, rows[i].dat, rd);
                    wait_idle();
                end
                default: begin
                    u_card_reader.present(1'b0);
                    rdchk(rows[i].adr, rows[i].dat);
                end
            endcase
        end
        $display("table rows done");
        // mode 1 zone two erase goes word by word
        cmd(OP_ERASE, TGT_AZ2, 7'd5, st);
        @(posedge core_clk);
        check("word erase", 32'h00000005, pw);
        $display("word erase done");
        // issuer blown: mode 2, maker and enable fuse frozen
        do_reset();
        u_card_reader.present(1'b0);
        cmd(OP_WRITE, TGT_ISSUER, 7'd0, st);
        rdchk(ADDR_FUSE, 32'h00030000);
        rdchk(ADDR_STATUS, 32'h00000023);
        cmd(OP_WRITE, TGT_MAKER, 7'd0, st);
        check("busy", 32'h0, {31'h0, st});
        rdchk(ADDR_MAKER, 32'h0000ffff);
        cmd(OP_WRITE, TGT_ECEN, 7'd0, st);
        rdchk(ADDR_FUSE, 32'h00030000);
        p0 = pulses;
        cmd(OP_ERASE, TGT_AZ2, 7'd0, st);
        check("erase no key", 32'(p0), 32'(pulses));
        u_card_reader.present(1'b1);
        rdchk(ADDR_STATUS, 32'h00000037);
        cmd(OP_ERASE, TGT_AZ2, 7'd0, st);
        check("erase unarmed", 32'h0, {31'h0, st});
        cmd(OP_WRITE, TGT_EC, 7'd0, st);
        cmd(OP_ERASE, TGT_EC, 7'd0, st);
        rdchk(ADDR_CNT0, 32'hfffffffe);
        $display("mode 2 locks done");
        // spend all 128 counter bits, one erase each
        for (int i = 0; i < 128; i++) begin
            if (i > 0) begin
                cmd(OP_WRITE, TGT_EC, 7'(i), st);
            end
            cmd(OP_ERASE, TGT_AZ2, 7'd0, st);
            check("counted erase", 32'h1, {31'h0, st});
        end
        @(posedge core_clk);
        check("erase count", 32'(p0 + 128), 32'(pulses));
        check("block erase", 32'h1, {31'h0, pw[5]});
        rdchk(ADDR_CNT0, 32'h0);
        rdchk(ADDR_CNT1, 32'h0);
        rdchk(ADDR_CNT2, 32'h0);
        rdchk(ADDR_CNT3, 32'h0);
        cmd(OP_ERASE, TGT_AZ2, 7'd0, st);
        check("erase spent", 32'h0, {31'h0, st});
        cmd(OP_ERASE, TGT_EC, 7'd9, st);
        rdchk(ADDR_CNT0, 32'h0);
        $display("counter run done");
        // enable fuse blown: no limit, slow reader this time
        do_reset();
        u_card_reader.idle_gap = 3;
        // reset is power-down: spent counter and mode come back erased
        rdchk(ADDR_CNT0, 32'hffffffff);
        rdchk(ADDR_STATUS, 32'h00000000);
        u_card_reader.present(1'b0);
        cmd(OP_WRITE, TGT_ECEN, 7'd0, st);
        rdchk(ADDR_FUSE, 32'h0002ffff);
        cmd(OP_ERASE, TGT_ECEN, 7'd0, st);
        rdchk(ADDR_FUSE, 32'h0003ffff);
        cmd(OP_WRITE, TGT_ECEN, 7'd0, st);
        cmd(OP_WRITE, TGT_ISSUER, 7'd0, st);
        u_card_reader.present(1'b1);
        rdchk(ADDR_STATUS, 32'h00000007);
        p0 = pulses;
        repeat (3) cmd(OP_ERASE, TGT_AZ2, 7'd0, st);
        @(posedge core_clk);
        check("free erases", 32'(p0 + 3), 32'(pulses));
        $display("unlimited erase done");
        end_of_test();
    end
endmodule
`default_nettype wire
